// [rtl/sbc_bank_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.svh"

module sbc_bank_ctl #(
    parameter int NB = 4,
    parameter logic [3:0] TRP_CYC = `SBC_TRP_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Bank requests and state
    sbc_bank_if.bank bif
);
    logic [NB-1:0] open_reg;
    logic [3:0] trp_reg [NB];
    sbc_pkg::sbc_row_t row_reg [NB];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            open_reg <= '0;
            for (int b = 0; b < NB; b++) begin
                trp_reg[b] <= 4'h0;
                row_reg[b] <= 13'h0000;
            end
        end else begin
            for (int b = 0; b < NB; b++) begin
                if (bif.pre[b]) begin
                    // Precharge wins over a same-cycle activate
                    // Counts only the cycles still blocked after the precharge edge
                    if (open_reg[b]) begin
                        trp_reg[b] <= TRP_CYC - 4'h1;
                    end
                    open_reg[b] <= 1'b0;
                end else if (bif.act[b] && !open_reg[b] && trp_reg[b] == 4'h0) begin
                    open_reg[b] <= 1'b1;
                    row_reg[b] <= bif.act_row;
                end else if (trp_reg[b] != 4'h0) begin
                    trp_reg[b] <= trp_reg[b] - 4'h1;
                end
            end
        end
    end

    always_comb begin
        for (int b = 0; b < NB; b++) begin
            bif.idle[b] = !open_reg[b] && trp_reg[b] == 4'h0;
            bif.row[b] = row_reg[b];
        end
    end

    assign bif.open = open_reg;
endmodule

`default_nettype wire

// [rtl/sbc_bank_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface sbc_bank_if #(parameter int NB = 4);
    logic [NB-1:0] act;
    logic [NB-1:0] pre;
    sbc_pkg::sbc_row_t act_row;
    logic [NB-1:0] open;
    logic [NB-1:0] idle;
    sbc_pkg::sbc_row_t row [NB];

    modport ctl (output act, pre, act_row, input open, idle, row);
    modport bank (input act, pre, act_row, output open, idle, row);
endinterface

`default_nettype wire

// [rtl/sbc_defines.svh]
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// Clock period and timing figures
`define SBC_CLK_NS 25
`define SBC_TRP_NS 20
`define SBC_TRP_CYC 4'((`SBC_TRP_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`define SBC_TMRD_CYC 2
`define SBC_READY_EXTRA 3
`define SBC_TDQZ_CYC 2

// Mode word layout and reset value
`define SBC_MODE_BLEN_LSB 0
`define SBC_MODE_BLEN_MSB 2
`define SBC_MODE_RLAT_LSB 4
`define SBC_MODE_RLAT_MSB 6
`define SBC_MODE_RST 13'h0020

// Address bit that selects all banks or auto precharge
`define SBC_A_AP 10

`endif

// [rtl/sbc_pkg.sv]
package sbc_pkg;

    typedef enum logic [2:0] {
        SBC_CMD_DESEL = 3'b000,
        SBC_CMD_NOP = 3'b001,
        SBC_CMD_READ = 3'b010,
        SBC_CMD_WRITE = 3'b011,
        SBC_CMD_ACTIVATE = 3'b100,
        SBC_CMD_PRECHARGE = 3'b101,
        SBC_CMD_REFRESH = 3'b110,
        SBC_CMD_MODE_SET = 3'b111
    } sbc_cmd_e;

    typedef enum logic [1:0] {
        SBC_POWERUP = 2'b00,
        SBC_MODE_WAIT = 2'b01,
        SBC_READY = 2'b10
    } sbc_init_e;

    typedef logic [12:0] sbc_row_t;

endpackage

// [rtl/sbc_sdram_device.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defines.svh"

// Summary of operation
// - Before mode set the device ignores activate, read and write; no bank opens, nothing is read.
// - Device is fully usable three clocks after mode set recovery.
// - Precharge with A10 low closes the addressed bank, idle after precharge period.
// - Precharge with A10 high closes every bank at once, except the bank of a running auto-precharge burst.
// - Deselect and no-operation start nothing; running bursts carry on.
// - Read and write decoded from strobes; length and latency from mode word.
// - Read latency two or three, burst length one, two or four, commands each clock.
// - Access with A10 high precharges its bank when the burst ends.
// - Precharge cuts plain bursts; auto-precharge bursts cannot be cut at their bank.
// - Mask during a cut read floats outputs two clocks later.
// - Cut write keeps data taken before precharge; masked data is not stored.
// - New read or write ends the current burst and starts immediately, unless aimed at the bank of a running auto-precharge burst.
module sbc_sdram_device #(
    parameter int DATA_W = 8,
    parameter int ROW_BITS = 2,
    parameter int COL_BITS = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Command and address pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bank_addr,
    input wire logic [12:0] addr,
    // Data pins
    input wire logic dqm,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    // Status
    output logic dev_ready,
    output logic [3:0] bank_open
);
    localparam int NB = 4;
    localparam int IDX_W = 2 + ROW_BITS + COL_BITS;
    localparam int DEPTH = 1 << IDX_W;
    localparam int TMRD_WAIT = `SBC_TMRD_CYC + `SBC_READY_EXTRA;
    localparam int TDQZ = `SBC_TDQZ_CYC;

    function automatic sbc_pkg::sbc_cmd_e decode_cmd(input logic cs, input logic [2:0] rcw);
        sbc_pkg::sbc_cmd_e c;
        c = sbc_pkg::SBC_CMD_NOP;
        if (cs) begin
            c = sbc_pkg::SBC_CMD_DESEL;
        end else begin
            case (rcw)
                3'b101: c = sbc_pkg::SBC_CMD_READ;
                3'b100: c = sbc_pkg::SBC_CMD_WRITE;
                3'b011: c = sbc_pkg::SBC_CMD_ACTIVATE;
                3'b010: c = sbc_pkg::SBC_CMD_PRECHARGE;
                3'b001: c = sbc_pkg::SBC_CMD_REFRESH;
                3'b000: c = sbc_pkg::SBC_CMD_MODE_SET;
                // Burst stop is not supported and acts as no-operation
                default: c = sbc_pkg::SBC_CMD_NOP;
            endcase
        end
        return c;
    endfunction

    function automatic logic [2:0] burst_beats(input logic [2:0] code);
        logic [2:0] n;
        case (code)
            3'h0: n = 3'h1;
            3'h1: n = 3'h2;
            3'h2: n = 3'h4;
            default: n = 3'h1;
        endcase
        return n;
    endfunction

    function automatic logic [NB-1:0] bank_bit(input logic [1:0] b);
        return NB'(1) << b;
    endfunction

    sbc_bank_if #(.NB(NB)) bif ();

    sbc_bank_ctl #(.NB(NB)) u_banks (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .bif(bif)
    );

    sbc_pkg::sbc_cmd_e cmd;
    sbc_pkg::sbc_init_e init_reg;
    logic [12:0] mode_reg;
    logic [2:0] init_cnt_reg;
    logic rd_busy_reg, wr_busy_reg, bst_ap_reg;
    logic [1:0] bst_bank_reg;
    logic [COL_BITS-1:0] bst_col_reg;
    logic [2:0] bst_left_reg;
    logic [DATA_W-1:0] mem [DEPTH];
    logic [DATA_W-1:0] pipe_data_reg [3];
    logic [2:0] pipe_vld_reg;
    logic [TDQZ-1:0] dqm_dly_reg;

    logic ready, busy, all_idle, rlat3, ap_locked;
    logic take_rw, take_act, take_mode, cmd_pre;
    logic beat, beat_wr, last_beat, ap_beat, ap_fire, term_ap, stop_burst;
    logic [1:0] beat_bank;
    logic [COL_BITS-1:0] beat_col;
    logic [2:0] beats;
    logic [NB-1:0] cmd_pre_vec;
    logic [IDX_W-1:0] idx;

    assign cmd = decode_cmd(cs_n, {ras_n, cas_n, we_n});
    assign ready = init_reg == sbc_pkg::SBC_READY;
    assign busy = rd_busy_reg || wr_busy_reg;
    assign all_idle = &bif.idle;
    assign beats = burst_beats(mode_reg[`SBC_MODE_BLEN_MSB:`SBC_MODE_BLEN_LSB]);
    assign rlat3 = mode_reg[`SBC_MODE_RLAT_MSB:`SBC_MODE_RLAT_LSB] == 3'h3;
    // An auto-precharge burst shields its own bank from any new command
    assign ap_locked = busy && bst_ap_reg && bank_addr == bst_bank_reg;

    // Until the mode is set only precharge and mode set do anything
    assign take_rw = ready && !ap_locked && bif.open[bank_addr]
        && (cmd == sbc_pkg::SBC_CMD_READ || cmd == sbc_pkg::SBC_CMD_WRITE);
    assign take_act = ready && cmd == sbc_pkg::SBC_CMD_ACTIVATE;
    assign take_mode = init_reg != sbc_pkg::SBC_MODE_WAIT && all_idle && !busy
        && cmd == sbc_pkg::SBC_CMD_MODE_SET;
    assign cmd_pre = init_reg != sbc_pkg::SBC_MODE_WAIT && cmd == sbc_pkg::SBC_CMD_PRECHARGE;

    always_comb begin
        cmd_pre_vec = '0;
        if (cmd_pre) begin
            cmd_pre_vec = addr[`SBC_A_AP] ? {NB{1'b1}} : bank_bit(bank_addr);
        end
        if (busy && bst_ap_reg) begin
            cmd_pre_vec[bst_bank_reg] = 1'b0;
        end
    end

    // One burst beat per clock, the first on the command edge itself
    assign beat = take_rw || busy;
    assign beat_wr = take_rw ? cmd == sbc_pkg::SBC_CMD_WRITE : wr_busy_reg;
    assign beat_bank = take_rw ? bank_addr : bst_bank_reg;
    assign beat_col = take_rw ? addr[COL_BITS-1:0] : bst_col_reg;
    assign last_beat = take_rw ? beats == 3'h1 : bst_left_reg == 3'h1;
    assign ap_beat = take_rw ? addr[`SBC_A_AP] : bst_ap_reg;
    assign stop_burst = busy && cmd_pre_vec[bst_bank_reg];
    assign ap_fire = beat && last_beat && ap_beat && !stop_burst;
    // An auto-precharge burst cut by a new access to another bank still closes its own bank
    assign term_ap = take_rw && busy && bst_ap_reg && !last_beat;
    assign idx = {beat_bank, bif.row[beat_bank][ROW_BITS-1:0], beat_col};

    assign bif.pre = cmd_pre_vec | (ap_fire ? bank_bit(beat_bank) : '0)
        | (term_ap ? bank_bit(bst_bank_reg) : '0);
    assign bif.act = take_act ? bank_bit(bank_addr) : '0;
    assign bif.act_row = addr;
    assign bank_open = bif.open;
    assign dev_ready = ready;

    // Mode set and recovery before full function
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            init_reg <= sbc_pkg::SBC_POWERUP;
            init_cnt_reg <= 3'h0;
            mode_reg <= `SBC_MODE_RST;
        end else begin
            case (init_reg)
                sbc_pkg::SBC_POWERUP, sbc_pkg::SBC_READY: begin
                    if (take_mode) begin
                        mode_reg <= addr;
                        init_reg <= sbc_pkg::SBC_MODE_WAIT;
                        init_cnt_reg <= 3'(TMRD_WAIT - 1);
                    end
                end
                sbc_pkg::SBC_MODE_WAIT: begin
                    init_cnt_reg <= init_cnt_reg - 3'h1;
                    if (init_cnt_reg == 3'h1) begin
                        init_reg <= sbc_pkg::SBC_READY;
                    end
                end
                default: init_reg <= sbc_pkg::SBC_POWERUP;
            endcase
        end
    end

    // Burst sequencing
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_busy_reg <= 1'b0;
            wr_busy_reg <= 1'b0;
            bst_ap_reg <= 1'b0;
            bst_bank_reg <= 2'h0;
            bst_col_reg <= '0;
            bst_left_reg <= 3'h0;
        end else if (take_rw) begin
            // A new access replaces the running burst at once
            rd_busy_reg <= cmd == sbc_pkg::SBC_CMD_READ && beats != 3'h1;
            wr_busy_reg <= cmd == sbc_pkg::SBC_CMD_WRITE && beats != 3'h1;
            bst_ap_reg <= addr[`SBC_A_AP];
            bst_bank_reg <= bank_addr;
            bst_col_reg <= addr[COL_BITS-1:0] + 1'b1;
            bst_left_reg <= beats - 3'h1;
        end else if (stop_burst || (busy && last_beat)) begin
            rd_busy_reg <= 1'b0;
            wr_busy_reg <= 1'b0;
            bst_left_reg <= 3'h0;
        end else if (busy) begin
            bst_col_reg <= bst_col_reg + 1'b1;
            bst_left_reg <= bst_left_reg - 3'h1;
        end
    end

    // Writes take data on the beat edge; masked beats and cut beats store nothing
    always_ff @(posedge ref_clk) begin
        if (beat && beat_wr && !dqm && !stop_burst) begin
            mem[idx] <= dq_in;
        end
    end

    // Read pipeline; latency picks the stage that reaches the pins
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pipe_vld_reg <= 3'h0;
            dqm_dly_reg <= '0;
            for (int i = 0; i < 3; i++) begin
                pipe_data_reg[i] <= '0;
            end
        end else begin
            pipe_vld_reg <= {pipe_vld_reg[1:0], beat && !beat_wr && !stop_burst};
            pipe_data_reg[0] <= mem[idx];
            pipe_data_reg[1] <= pipe_data_reg[0];
            pipe_data_reg[2] <= pipe_data_reg[1];
            dqm_dly_reg <= {dqm_dly_reg[TDQZ-2:0], dqm};
        end
    end

    assign dq_out = rlat3 ? pipe_data_reg[2] : pipe_data_reg[1];
    // Mask floats the pins two clocks later, guarding against write collision
    assign dq_oe = (rlat3 ? pipe_vld_reg[2] : pipe_vld_reg[1]) && !dqm_dly_reg[TDQZ-1];

    a_powerup_ignore: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !dev_ready |=> (bank_open & ~$past(bank_open)) == 4'h0)
        else $error("bank opened before mode set");

    a_ready_after_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
        take_mode |-> ##1 !dev_ready ##(TMRD_WAIT - 1) dev_ready)
        else $error("device not ready three clocks after mode recovery");

    a_single_pre: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cmd_pre && !addr[`SBC_A_AP] && !ap_locked |=> !bank_open[$past(bank_addr)])
        else $error("addressed bank still open after precharge");

    a_all_pre: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cmd_pre && addr[`SBC_A_AP] && !busy |=> bank_open == 4'h0)
        else $error("bank still open after precharge all");

    a_idle_no_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (cmd == sbc_pkg::SBC_CMD_DESEL || cmd == sbc_pkg::SBC_CMD_NOP) && busy
        && bst_left_reg > 3'h1 |=> busy && bst_left_reg == $past(bst_left_reg) - 3'h1)
        else $error("idle command disturbed a running burst");

    a_read_latency: assert property (@(posedge ref_clk) disable iff (!reset_n)
        take_rw && cmd == sbc_pkg::SBC_CMD_READ && !dqm && !rlat3 |-> ##2 dq_oe)
        else $error("read data missing at latency two");

    a_burst_four: assert property (@(posedge ref_clk) disable iff (!reset_n)
        take_rw && beats == 3'h4 |=> busy && bst_left_reg == 3'h3)
        else $error("burst of four not set up");

    a_auto_close: assert property (@(posedge ref_clk) disable iff (!reset_n)
        take_rw && addr[`SBC_A_AP] && beats == 3'h1 |=> !bank_open[$past(bank_addr)])
        else $error("auto precharge did not close bank");

    a_ap_uncut: assert property (@(posedge ref_clk) disable iff (!reset_n)
        busy && bst_ap_reg && bst_left_reg > 3'h1 && cmd_pre |=> bank_open[$past(bst_bank_reg)])
        else $error("auto precharge burst cut by precharge");

    a_write_cut: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_busy_reg && stop_burst |=> !busy)
        else $error("write burst survived precharge");
endmodule

`default_nettype wire

// [sim/sbc_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none

module sbc_ctl_model #(
    parameter int DESEL_CYC = 40000,
    parameter int PAUSE_CYC = 8000,
    parameter int TRCD = 2,
    parameter int TRRD = 2
) (
    // Clock
    input wire logic ref_clk,
    // Command pins
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] bank_addr,
    output logic [12:0] addr,
    // Data pins
    output logic dqm,
    output logic [7:0] dq_in
);
    localparam logic [3:0] C_DES = 4'h8, C_NOP = 4'h7, C_PRE = 4'h2, C_REF = 4'h1, C_ACT = 4'h3;
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        bank_addr = 2'h0;
        addr = 13'h0000;
        dqm = 1'b0;
        dq_in = 8'h00;
    end
    // One command per call, entered just after a rising edge
    task automatic step(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                        input logic m, input logic [7:0] d);
        {cs_n, ras_n, cas_n, we_n} = c;
        bank_addr = b;
        addr = a;
        dqm = m;
        dq_in = d;
        @(posedge ref_clk);
        #1;
    endtask
    // Idle data lines toggle so a stale value never looks valid
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            step(C_NOP, 2'h0, 13'h0000, 1'b0, ~dq_in);
        end
    endtask
    // Deselect with junk strobes and addresses, pause, precharge all, then eight refreshes; mode set follows
    task automatic init_seq();
        for (int i = 0; i < DESEL_CYC; i++) begin
            step(C_DES | 4'(i % 8), 2'(i), 13'(i), 1'b0, ~dq_in);
        end
        step(C_NOP, 2'h0, 13'h0000, 1'b0, ~dq_in);
        for (int i = 0; i < PAUSE_CYC; i++) begin
            step(C_DES, 2'h0, 13'h0000, 1'b0, ~dq_in);
        end
        step(C_PRE, 2'h0, 13'h0400, 1'b0, ~dq_in);
        for (int i = 0; i < 8; i++) begin
            step(C_REF, 2'h0, 13'h0000, 1'b0, ~dq_in);
            idle(1);
        end
    endtask
    // Waiting the longer of both delays keeps any next activate legal too
    task automatic open_row(input logic [1:0] b, input logic [12:0] row);
        step(C_ACT, b, row, 1'b0, ~dq_in);
        idle(TRCD > TRRD ? TRCD : TRRD);
    endtask
endmodule

`default_nettype wire

// [sim/sbc_sdram_device_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module sbc_sdram_device_tb;
    localparam logic [3:0] C_DES = 4'h8, C_NOP = 4'h7, C_RD = 4'h5, C_WR = 4'h4;
    localparam logic [3:0] C_PRE = 4'h2, C_MRS = 4'h0;
    localparam int LIMIT = 60000;
    typedef struct {
        logic lat3;
        logic [2:0] bcode;
        logic [1:0] bank;
        logic [12:0] row;
        logic [3:0] col;
        logic [7:0] base;
        int bl;
    } sbc_case_s;
    logic ref_clk, reset_n, cs_n, ras_n, cas_n, we_n, dqm, dq_oe, dev_ready;
    logic [1:0] bank_addr;
    logic [12:0] addr;
    logic [7:0] dq_in, dq_out;
    logic [3:0] bank_open;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    sbc_case_s cases [4] = '{
        '{1'b0, 3'h0, 2'h0, 13'h0001, 4'h3, 8'hA0, 1},
        '{1'b0, 3'h1, 2'h1, 13'h0002, 4'hF, 8'hB0, 2},
        '{1'b1, 3'h2, 2'h2, 13'h0003, 4'hE, 8'hD0, 4},
        '{1'b1, 3'h1, 2'h3, 13'h0000, 4'h0, 8'hE0, 2}
    };

    sbc_sdram_device uut (
        .ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .bank_addr(bank_addr), .addr(addr), .dqm(dqm), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .dev_ready(dev_ready), .bank_open(bank_open)
    );
    sbc_ctl_model ctl (
        .ref_clk(ref_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_addr(bank_addr), .addr(addr), .dqm(dqm), .dq_in(dq_in)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Output drive and data of the current cycle
    task automatic look(input logic oe, input logic [7:0] w);
        check("dq_oe", 16'(dq_oe), 16'(oe));
        if (oe) begin
            check("dq_out", 16'(dq_out), 16'(w));
        end
    endtask

    task automatic set_mode(input logic lat3, input logic [2:0] bc);
        int n;
        n = 0;
        ctl.step(C_MRS, 2'h0, 13'({lat3 ? 3'h3 : 3'h2, 1'b0, bc}), 1'b0, ~dq_in);
        check("dev_ready", 16'(dev_ready), 16'h0000);
        while (dev_ready !== 1'b1 && n < 8) begin
            ctl.idle(1);
            n++;
        end
        check("ready_wait", 16'(n <= 4), 16'h0001);
    endtask

    // Write a burst, read it back with auto precharge
    task automatic run_case(input sbc_case_s t);
        int lat;
        lat = t.lat3 ? 3 : 2;
        set_mode(t.lat3, t.bcode);
        ctl.open_row(t.bank, t.row);
        for (int k = 0; k < t.bl; k++) begin
            ctl.step(k == 0 ? C_WR : C_NOP, t.bank, 13'(t.col), 1'b0, t.base + 8'(k));
        end
        ctl.idle(2);
        ctl.step(C_RD, t.bank, 13'h0400 | 13'(t.col), 1'b0, ~dq_in);
        for (int c = 1; c <= lat + t.bl; c++) begin
            look(c >= lat && c < lat + t.bl, t.base + 8'(c - lat));
            ctl.idle(1);
        end
        check("bank_open", 16'(bank_open[t.bank]), 16'h0000);
    endtask

    initial begin
        reset_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        // Commands before mode set must do nothing
        ctl.step(4'h3, 2'h1, 13'h1FFF, 1'b0, 8'h5A);
        ctl.step(C_RD, 2'h1, 13'h0000, 1'b0, 8'hA5);
        ctl.idle(1);
        check("dq_oe", 16'(dq_oe), 16'h0000);
        check("bank_open", 16'(bank_open), 16'h0000);
        ctl.init_seq();
        foreach (cases[i]) begin
            run_case(cases[i]);
        end
        set_mode(1'b0, 3'h2);
        ctl.open_row(2'h0, 13'h0001);
        ctl.open_row(2'h2, 13'h0001);
        ctl.step(C_PRE, 2'h2, 13'h0000, 1'b0, ~dq_in);
        check("bank_open", 16'(bank_open), 16'h0001);
        ctl.open_row(2'h3, 13'h0002);
        ctl.step(C_PRE, 2'h1, 13'h0400, 1'b0, ~dq_in);
        check("bank_open", 16'(bank_open), 16'h0000);
        ctl.idle(1);
        // Masked beat keeps old data, second write cuts the first
        ctl.open_row(2'h1, 13'h0002);
        ctl.step(C_WR, 2'h1, 13'h000F, 1'b0, 8'hC0);
        ctl.step(C_NOP, 2'h1, 13'h0000, 1'b1, 8'hC1);
        for (int k = 4; k < 8; k++) begin
            ctl.step(k == 4 ? C_WR : C_NOP, 2'h1, 13'h0004, 1'b0, 8'hC0 + 8'(k));
        end
        ctl.idle(2);
        ctl.step(C_RD, 2'h1, 13'h000F, 1'b0, ~dq_in);
        look(1'b0, 8'h00);
        ctl.step(C_DES, 2'h1, 13'h0400, 1'b0, ~dq_in);
        look(1'b1, 8'hC0);
        ctl.step(C_RD, 2'h1, 13'h0004, 1'b0, ~dq_in);
        look(1'b1, 8'hB1);
        for (int k = 4; k < 8; k++) begin
            ctl.idle(1);
            look(1'b1, 8'hC0 + 8'(k));
        end
        ctl.idle(1);
        look(1'b0, 8'h00);
        check("dev_ready", 16'(dev_ready), 16'h0001);
        // Auto precharge read ignores a precharge to its bank
        ctl.step(C_RD, 2'h1, 13'h0404, 1'b0, ~dq_in);
        ctl.step(C_PRE, 2'h1, 13'h0000, 1'b0, ~dq_in);
        check("bank_open", 16'(bank_open[1]), 16'h0001);
        for (int k = 4; k < 8; k++) begin
            look(1'b1, 8'hC0 + 8'(k));
            ctl.idle(1);
        end
        check("bank_open", 16'(bank_open[1]), 16'h0000);
        // Latency three, burst four from here on
        set_mode(1'b1, 3'h2);
        // Write cut by precharge keeps the early beat; masked beat keeps old data
        ctl.open_row(2'h1, 13'h0002);
        ctl.step(C_WR, 2'h1, 13'h0004, 1'b0, 8'h94);
        ctl.step(C_NOP, 2'h1, 13'h0000, 1'b1, 8'h95);
        ctl.step(C_PRE, 2'h1, 13'h0000, 1'b0, 8'h96);
        check("bank_open", 16'(bank_open[1]), 16'h0000);
        // Activate one precharge period later, then read with a late precharge
        ctl.open_row(2'h1, 13'h0002);
        ctl.step(C_RD, 2'h1, 13'h0004, 1'b0, ~dq_in);
        ctl.idle(2);
        for (int k = 4; k < 8; k++) begin
            look(1'b1, k == 4 ? 8'h94 : 8'hC0 + 8'(k));
            ctl.step(k == 6 ? C_PRE : C_NOP, 2'h1, 13'h0000, 1'b0, ~dq_in);
        end
        check("bank_open", 16'(bank_open[1]), 16'h0000);
        // Plain read cut by precharge, mask floats the word still in the pipe
        ctl.open_row(2'h1, 13'h0002);
        ctl.step(C_RD, 2'h1, 13'h0004, 1'b0, ~dq_in);
        ctl.step(C_NOP, 2'h1, 13'h0000, 1'b0, ~dq_in);
        ctl.step(C_PRE, 2'h1, 13'h0000, 1'b1, ~dq_in);
        look(1'b1, 8'h94);
        check("bank_open", 16'(bank_open[1]), 16'h0000);
        for (int k = 0; k < 3; k++) begin
            ctl.step(C_NOP, 2'h0, 13'h0000, 1'b1, ~dq_in);
            look(1'b0, 8'h00);
        end
        // Reset in mid-run closes the open bank and drops ready at once
        ctl.open_row(2'h0, 13'h0001);
        reset_n = 1'b0;
        #1;
        check("bank_open", 16'(bank_open), 16'h0000);
        check("dev_ready", 16'(dev_ready), 16'h0000);
        @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        // Activate at the first edge after release is ignored before mode set
        ctl.step(4'h3, 2'h2, 13'h0000, 1'b0, 8'h00);
        check("bank_open", 16'(bank_open), 16'h0000);
        ctl.idle(1);
        stop_test();
    end
endmodule

`default_nettype wire
